// [src/smbcs_pkg.sv]
// Shared constants for the management-bus configuration slave.
package smbcs_pkg;

  // ==========================================================================
  // Configuration source selection
  // ==========================================================================
  localparam logic [1:0] SRC_DEFAULT = 2'h0;
  localparam logic [1:0] SRC_MGMT_BUS = 2'h1;
  localparam logic [1:0] SRC_EEPROM = 2'h2;

  // ==========================================================================
  // Protocol constants
  // ==========================================================================
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [7:0] MAX_BLOCK_BYTES = 8'h20;
  localparam logic [7:0] UNDEFINED_READ_VALUE = 8'h00;
  localparam logic [7:0] STATUS_CMD_ADDR = 8'hff;
  localparam int ATTACH_BIT = 0;
  localparam int SOFT_RESET_BIT = 1;
  localparam int POWER_DOWN_BIT = 2;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ = 40_000_000;
  localparam int TIMEOUT_MIN_MS = 25;
  localparam int TIMEOUT_MAX_MS = 35;
  localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * 30;
  localparam int OPERATIONAL_US = 500;
  localparam int OPERATIONAL_CYCLES = CLK_HZ / 1_000_000 * OPERATIONAL_US;
  localparam int EEPROM_LOAD_MAX_US = 99_500;
  localparam int EEPROM_LOAD_CYCLES = CLK_HZ / 1_000_000 * EEPROM_LOAD_MAX_US;
  localparam int RESET_MIN_NS = 1000;

endpackage

// [src/smbcs_sync_edge.sv]
// Two-stage synchroniser with edge detection for one bus line.
`timescale 1ns/1ps
`default_nettype none

module smbcs_sync_edge (
  input wire logic mclk,
  input wire logic rst,
  input wire logic line_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ==========================================================================
  // Sampling chain
  // ==========================================================================
  // The first stage feeds only the second so metastability cannot leak.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
    end else begin
      stage1 <= line_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Edges compare the settled stage with its one-cycle-older copy.
  assign level = stage2;
  assign rise = stage2 & ~stage3;
  assign fall = ~stage2 & stage3;

endmodule

`default_nettype wire

// [src/smbcs_slave.sv]
// Management-bus block read and write slave with reset and attach sequencing.
`timescale 1ns/1ps
`default_nettype none

module smbcs_slave #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2c,
  parameter int NUM_REGS = 256,
  parameter int NUM_LEDS = 3,
  parameter int TIMEOUT_CYCLES = smbcs_pkg::TIMEOUT_CYCLES,
  parameter int OPERATIONAL_CYCLES = smbcs_pkg::OPERATIONAL_CYCLES,
  parameter int EEPROM_LOAD_CYCLES = smbcs_pkg::EEPROM_LOAD_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic config_source_select_hi,
  input wire logic config_source_select_lo,
  input wire logic mgmt_serial_clock,
  input wire logic mgmt_serial_data_in,
  output logic mgmt_serial_data_out,
  output logic mgmt_serial_data_oe,
  input wire logic eeprom_load_done,
  output logic eeprom_load_start,
  output logic eeprom_path_enable,
  input wire logic [NUM_LEDS-1:0] led_strap_in,
  input wire logic led_on,
  output logic [NUM_LEDS-1:0] led_drive,
  output logic [NUM_LEDS-1:0] led_strap,
  output logic [2:0] port_power_control,
  output logic hub_operational,
  output logic usb_attach,
  output logic config_locked,
  output logic block_write_done,
  output logic protocol_error
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_CMD = 4'h2,
    ST_COUNT = 4'h3,
    ST_WDATA = 4'h4,
    ST_RCOUNT = 4'h5,
    ST_RADDR = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8,
    ST_IGNORE = 4'h9
  } smbcs_state_t;

  smbcs_state_t state;
  logic scl, scl_rise, scl_fall;
  logic sda, sda_rise, sda_fall;
  logic start_cond, stop_cond;
  logic mgmt_mode;
  logic [7:0] regs [NUM_REGS];
  logic [7:0] stage [32];
  logic [7:0] shift;
  logic [3:0] bitcnt;
  logic ack_phase;
  logic [7:0] cmd;
  logic [7:0] count;
  logic [7:0] index;
  logic just_started;
  logic [31:0] low_cnt;
  logic [31:0] op_cnt;
  logic [31:0] ee_cnt;
  logic commit;
  logic soft_reset;
  logic strap_taken;
  logic [7:0] rd_byte;

  // ==========================================================================
  // Line sampling
  // ==========================================================================
  smbcs_sync_edge u_scl (
    .mclk(mclk),
    .rst(rst),
    .line_in(mgmt_serial_clock),
    .level(scl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  smbcs_sync_edge u_sda (
    .mclk(mclk),
    .rst(rst),
    .line_in(mgmt_serial_data_in),
    .level(sda),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  // Data changing while the clock is high marks start and stop.
  assign start_cond = scl & sda_fall & mgmt_mode;
  assign stop_cond = scl & sda_rise & mgmt_mode;
  assign mgmt_mode = {config_source_select_hi, config_source_select_lo}
                     == smbcs_pkg::SRC_MGMT_BUS;

  // Undefined or out-of-range addresses read zero.
  always_comb begin
    if (32'(index) < NUM_REGS) begin
      rd_byte = regs[index];
    end else begin
      rd_byte = smbcs_pkg::UNDEFINED_READ_VALUE;
    end
  end

  // ==========================================================================
  // Hardware reset recovery and configuration sequencing
  // ==========================================================================
  // The operational counter models the recovery time after reset release.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_cnt <= '0;
      hub_operational <= 1'b0;
    end else if (op_cnt < 32'(OPERATIONAL_CYCLES)) begin
      op_cnt <= op_cnt + 32'h1;
    end else begin
      hub_operational <= 1'b1;
    end
  end

  // EEPROM loading starts once operational and carries a watchdog bound.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eeprom_load_start <= 1'b0;
      eeprom_path_enable <= 1'b0;
      ee_cnt <= '0;
    end else begin
      eeprom_path_enable <= ~mgmt_mode;
      eeprom_load_start <= hub_operational & ~mgmt_mode
                           & (config_source_select_hi | config_source_select_lo)
                           & ~eeprom_load_done
                           & (ee_cnt < 32'(EEPROM_LOAD_CYCLES));
      if (eeprom_load_start) begin
        ee_cnt <= ee_cnt + 32'h1;
      end
    end
  end

  // Attach waits without limit on the attach bit in bus mode.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      usb_attach <= 1'b0;
      config_locked <= 1'b0;
      port_power_control <= 3'h0;
    end else if (soft_reset) begin
      usb_attach <= 1'b0;
      config_locked <= 1'b0;
      // Power keeps following attach one cycle late, even through a soft reset.
      port_power_control <= {3{usb_attach}};
    end else begin
      if (mgmt_mode) begin
        usb_attach <= hub_operational & regs[smbcs_pkg::STATUS_CMD_ADDR]
                      [smbcs_pkg::ATTACH_BIT];
        config_locked <= regs[smbcs_pkg::STATUS_CMD_ADDR][smbcs_pkg::ATTACH_BIT];
      end else begin
        usb_attach <= hub_operational & (eeprom_load_done | ~eeprom_path_enable
                      | ~(config_source_select_hi | config_source_select_lo));
        config_locked <= 1'b0;
      end
      port_power_control <= {3{usb_attach}};
    end
  end

  // ==========================================================================
  // Strap capture and indicator drive
  // ==========================================================================
  // In default mode, straps are caught by a clocked process right after reset release.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_taken <= 1'b0;
      led_strap <= '0;
      led_drive <= '0;
    end else begin
      if (!strap_taken) begin
        strap_taken <= 1'b1;
        if ({config_source_select_hi, config_source_select_lo}
            == smbcs_pkg::SRC_DEFAULT) begin
          led_strap <= led_strap_in;
        end
      end
      // A high strap means active-low drive, a low strap active-high.
      led_drive <= strap_taken ? (led_strap ^ {NUM_LEDS{led_on}}) : '0;
    end
  end

  // ==========================================================================
  // Clock-low time-out
  // ==========================================================================
  // A single over-long low interval aborts the transfer, between 25 and 35 ms.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_cnt <= '0;
    end else if (scl || state == ST_IDLE) begin
      low_cnt <= '0;
    end else if (low_cnt < 32'(TIMEOUT_CYCLES)) begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  // ==========================================================================
  // Protocol engine
  // ==========================================================================
  // The engine only samples the clock and never drives it, so stretching
  // by other devices just delays edges.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      shift <= '0;
      bitcnt <= '0;
      ack_phase <= 1'b0;
      cmd <= '0;
      count <= '0;
      index <= '0;
      just_started <= 1'b0;
      commit <= 1'b0;
      protocol_error <= 1'b0;
      mgmt_serial_data_out <= 1'b0;
      mgmt_serial_data_oe <= 1'b0;
    end else begin
      commit <= 1'b0;
      protocol_error <= 1'b0;
      if (soft_reset || low_cnt >= 32'(TIMEOUT_CYCLES)) begin
        state <= ST_IDLE;
        mgmt_serial_data_oe <= 1'b0;
      end else if (start_cond) begin
        // After the command byte, a repeated start turns the frame into a read.
        if (state == ST_COUNT) begin
          state <= ST_RADDR;
          count <= smbcs_pkg::MAX_BLOCK_BYTES;
        end else begin
          if (state != ST_IDLE && state != ST_IGNORE) begin
            protocol_error <= 1'b1;
          end
          state <= ST_ADDR;
        end
        bitcnt <= '0;
        ack_phase <= 1'b0;
        just_started <= 1'b1;
        mgmt_serial_data_oe <= 1'b0;
      end else if (stop_cond) begin
        // A stop right after start is the bus reset; any stop ends the frame.
        if (state == ST_WDATA && count == 8'h00 && !ack_phase) begin
          commit <= 1'b1;
        end else if (state != ST_IDLE && state != ST_IGNORE && !just_started
                     && state != ST_RDATA && state != ST_RACK) begin
          protocol_error <= 1'b1;
        end
        state <= ST_IDLE;
        mgmt_serial_data_oe <= 1'b0;
      end else if (scl_rise && !ack_phase && state != ST_IDLE && state != ST_IGNORE) begin
        just_started <= 1'b0;
        shift <= {shift[6:0], sda};
        bitcnt <= bitcnt + 4'h1;
      end else if (scl_rise && ack_phase && state == ST_RACK) begin
        // A master not-acknowledge ends the read.
        state <= sda ? ST_IGNORE : ST_RDATA;
      end else if (scl_fall && state != ST_IDLE && state != ST_IGNORE) begin
        if (ack_phase) begin
          ack_phase <= 1'b0;
          bitcnt <= '0;
          if (state == ST_RCOUNT) begin
            // The address-read acknowledge is followed by the byte count.
            state <= ST_RDATA;
            shift <= count;
            mgmt_serial_data_oe <= ~count[7];
            mgmt_serial_data_out <= 1'b0;
          end else if (state == ST_RDATA) begin
            shift <= rd_byte;
            mgmt_serial_data_oe <= ~rd_byte[7];
            mgmt_serial_data_out <= 1'b0;
          end else begin
            mgmt_serial_data_oe <= 1'b0;
          end
        end else if (bitcnt == 4'h8) begin
          ack_phase <= 1'b1;
          mgmt_serial_data_out <= 1'b0;
          mgmt_serial_data_oe <= 1'b1;
          unique case (state)
            ST_ADDR, ST_RADDR: begin
              // Mismatch, general call or wrong direction gets no answer.
              if (shift[7:1] != SLAVE_ADDR || shift[7:1] == smbcs_pkg::GENERAL_CALL_ADDR
                  || shift[0] != (state == ST_RADDR)) begin
                state <= ST_IGNORE;
                mgmt_serial_data_oe <= 1'b0;
              end else if (state == ST_RADDR) begin
                state <= ST_RCOUNT;
                index <= cmd - 8'h1; // The count byte advances it onto cmd.
              end else begin
                state <= ST_CMD;
              end
            end
            ST_CMD: begin
              cmd <= shift;
              index <= '0;
              state <= ST_COUNT;
            end
            ST_COUNT: begin
              if (shift == 8'h00 || shift > smbcs_pkg::MAX_BLOCK_BYTES) begin
                state <= ST_IGNORE;
                mgmt_serial_data_oe <= 1'b0;
                protocol_error <= 1'b1;
              end else begin
                count <= shift;
                state <= ST_WDATA;
              end
            end
            ST_WDATA: begin
              if (count == 8'h00) begin
                state <= ST_IGNORE;
                mgmt_serial_data_oe <= 1'b0;
                protocol_error <= 1'b1;
              end else begin
                stage[index[4:0]] <= shift;
                index <= index + 8'h1;
                count <= count - 8'h1;
              end
            end
            ST_RDATA: begin
              state <= ST_RACK;
              mgmt_serial_data_oe <= 1'b0;
              index <= index + 8'h1;
            end
            default: begin
              state <= ST_IGNORE;
              mgmt_serial_data_oe <= 1'b0;
            end
          endcase
        end else if (state == ST_RDATA) begin
          // The rising edge already shifted, so the top bit is the next one out.
          mgmt_serial_data_oe <= ~shift[7];
        end
      end
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  // Staged bytes land only on a clean stop; protected space ignores them.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= smbcs_pkg::REG_RESET_VALUE;
      end
      soft_reset <= 1'b0;
      block_write_done <= 1'b0;
    end else begin
      soft_reset <= 1'b0;
      block_write_done <= commit;
      if (soft_reset) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          regs[i] <= smbcs_pkg::REG_RESET_VALUE;
        end
      end else if (commit) begin
        for (int i = 0; i < 32; i++) begin
          if (8'(i) < index && 32'(cmd) + i < NUM_REGS) begin
            if (8'(32'(cmd) + i) == smbcs_pkg::STATUS_CMD_ADDR) begin
              regs[8'(32'(cmd) + i)] <= stage[i] & 8'h07;
              soft_reset <= stage[i][smbcs_pkg::SOFT_RESET_BIT];
            end else if (!config_locked) begin
              regs[8'(32'(cmd) + i)] <= stage[i];
            end
          end
        end
      end
    end
  end

  // No alert output is provided.

endmodule

`default_nettype wire

// [bench/smbcs_monitor.sv]
// Port-level checks for the management-bus configuration slave.
`timescale 1ns/1ps
`default_nettype none
module smbcs_monitor #(
  parameter int TIMEOUT_CYCLES = 200,
  parameter int OPERATIONAL_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic config_source_select_hi,
  input wire logic config_source_select_lo,
  input wire logic mgmt_serial_clock,
  input wire logic mgmt_serial_data_oe,
  input wire logic eeprom_path_enable,
  input wire logic [2:0] port_power_control,
  input wire logic hub_operational,
  input wire logic usb_attach,
  input wire logic config_locked,
  input wire logic block_write_done
);
  // ==========
  // Helper logic
  int low_cnt;
  int run_cnt;
  logic mgmt;
  // Counters saturate so that a long idle stretch cannot wrap them.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_cnt <= 0;
      run_cnt <= 0;
    end else begin
      low_cnt <= mgmt_serial_clock ? 0 : low_cnt + (low_cnt < 32'h3fffffff ? 1 : 0);
      run_cnt <= run_cnt + (run_cnt < 32'h3fffffff ? 1 : 0);
    end
  end
  // Bus-loaded configuration is selected.
  assign mgmt = {config_source_select_hi, config_source_select_lo} == 2'h1;
  default clocking mon_cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ==========
  // Assertions
  early_up_a: assert property (run_cnt < OPERATIONAL_CYCLES - 1 |-> !hub_operational)
    else $error("hub operational too early");
  late_up_a: assert property (run_cnt > OPERATIONAL_CYCLES + 2 |-> hub_operational)
    else $error("hub not operational in time");
  path_off_a: assert property (mgmt && $past(mgmt) |-> !eeprom_path_enable)
    else $error("eeprom path enabled in bus mode");
  attach_cause_a: assert property ($rose(usb_attach) && mgmt |->
    block_write_done || $past(block_write_done)) else $error("attach without a write");
  attach_lock_a: assert property (usb_attach && mgmt |-> config_locked)
    else $error("attached while still writable");
  power_follow_a: assert property (port_power_control == {3{$past(usb_attach)}})
    else $error("port power not tracking attach");
  timeout_a: assert property (low_cnt > TIMEOUT_CYCLES + 8 |-> !mgmt_serial_data_oe)
    else $error("data held after clock time-out");
  data_on_low_a: assert property ($changed(mgmt_serial_data_oe) |-> !mgmt_serial_clock)
    else $error("data moved while clock high");
  write_pulse_a: assert property (block_write_done |=> !block_write_done)
    else $error("write pulse longer than one cycle");
endmodule

bind smbcs_slave smbcs_monitor #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .OPERATIONAL_CYCLES(OPERATIONAL_CYCLES)
) u_monitor (
  .mclk(mclk), .rst(rst), .config_source_select_hi(config_source_select_hi),
  .config_source_select_lo(config_source_select_lo), .mgmt_serial_clock(mgmt_serial_clock),
  .mgmt_serial_data_oe(mgmt_serial_data_oe), .eeprom_path_enable(eeprom_path_enable),
  .port_power_control(port_power_control), .hub_operational(hub_operational),
  .usb_attach(usb_attach), .config_locked(config_locked), .block_write_done(block_write_done)
);
`default_nettype wire

// [bench/smbcs_host_model.sv]
// Behavioural management-bus host driving the slave's serial pins.
`timescale 1ns/1ps
`default_nettype none
module smbcs_host_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // One third of a data bit time in core clocks, long enough for the slave's sampler.
  localparam int Q = 8;
  int acks;
  logic [7:0] rcnt;
  logic [7:0] rbuf [32];
  // Both lines start released, so the pull-ups hold them high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (Q) @(posedge mclk);
  endtask
  // ==========
  // Bus primitives
  // Start or repeated start when is_stop is low, stop otherwise; data moves with clock high.
  task automatic cond(input logic is_stop);
    sda_low <= is_stop;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= !is_stop;
    tick();
    scl <= is_stop;
    tick();
  endtask
  // One byte each way; an all-ones byte leaves the line to the slave.
  task automatic xfer(input logic [7:0] b, input logic ack_out, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      tick();
      scl <= 1'b1;
      tick();
      got[i] = sda;
      scl <= 1'b0;
      tick();
    end
    sda_low <= ack_out;
    tick();
    scl <= 1'b1;
    tick();
    acks += (!ack_out && sda === 1'b0) ? 1 : 0;
    scl <= 1'b0;
    tick();
  endtask
  // ==========
  // Block transfers
  // The count goes out as given, so refused counts can be exercised.
  task automatic blk_wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] n,
                        input logic [7:0] base);
    logic [7:0] junk;
    acks = 0;
    cond(1'b0);
    xfer({a, 1'b0}, 1'b0, junk);
    xfer(c, 1'b0, junk);
    xfer(n, 1'b0, junk);
    for (int i = 0; i < n; i++) begin
      xfer(base + i[7:0], 1'b0, junk);
    end
    cond(1'b1);
  endtask
  // The last byte is not acknowledged so the slave lets go before the stop.
  task automatic blk_rd(input logic [6:0] a, input logic [7:0] c, input int n);
    logic [7:0] junk;
    acks = 0;
    cond(1'b0);
    xfer({a, 1'b0}, 1'b0, junk);
    xfer(c, 1'b0, junk);
    cond(1'b0);
    xfer({a, 1'b1}, 1'b0, junk);
    xfer(8'hff, 1'b1, rcnt);
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i < n - 1, rbuf[i]);
    end
    cond(1'b1);
  endtask
endmodule
`default_nettype wire

// [bench/test_smbus_config_slave.sv]
// Self-checking bench for the management-bus configuration slave.
`timescale 1ns/1ps
`default_nettype none
module test_smbus_config_slave;
  localparam logic [6:0] ADDR = 7'h2c;
  localparam int TO = 200;
  localparam int OPC = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sel_hi = 1'b0;
  logic sel_lo = 1'b1;
  logic load_done = 1'b0;
  logic led_on = 1'b0;
  logic [2:0] strap = 3'h5;
  wire logic scl, host_low, dut_oe, sda, ld_start, path_en, op, attach, locked, wr_done;
  wire logic [2:0] led_drive, led_strap, ppc;
  wire logic sdo, perr;
  int errors = 0;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int writes = 0;
  // Released data reads high through the pull-up.
  assign sda = !(host_low || dut_oe);
  // Core clock at 40 MHz.
  always #12.5 mclk = ~mclk;
  smbcs_slave #(.SLAVE_ADDR(ADDR), .TIMEOUT_CYCLES(TO), .OPERATIONAL_CYCLES(OPC),
    .EEPROM_LOAD_CYCLES(100)) dut (
    .mclk(mclk), .rst(rst), .config_source_select_hi(sel_hi),
    .config_source_select_lo(sel_lo), .mgmt_serial_clock(scl), .mgmt_serial_data_in(sda),
    .mgmt_serial_data_out(sdo), .mgmt_serial_data_oe(dut_oe), .eeprom_load_done(load_done),
    .eeprom_load_start(ld_start), .eeprom_path_enable(path_en), .led_strap_in(strap),
    .led_on(led_on), .led_drive(led_drive), .led_strap(led_strap), .port_power_control(ppc),
    .hub_operational(op), .usb_attach(attach), .config_locked(locked),
    .block_write_done(wr_done), .protocol_error(perr));
  smbcs_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(host_low));
  // Hang ceiling, and a count of committed writes.
  always @(posedge mclk) begin
    cycles++;
    if (wr_done === 1'b1) begin
      writes++;
    end
    if (perr === 1'b1) begin
      errors++;
    end
    if (cycles == 40000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset(input logic hi, input logic lo);
    @(posedge mclk);
    rst <= 1'b1;
    sel_hi <= hi;
    sel_lo <= lo;
    repeat (48) @(posedge mclk);
    rst <= 1'b0;
  endtask
  task automatic t_power_up();
    repeat (15) @(posedge mclk);
    check({attach, ppc, led_drive, op}, 8'h00);
    @(posedge mclk);
    rst <= 1'b0;
    repeat (OPC - 2) @(posedge mclk);
    check(op, 1'b0);
    repeat (6) @(posedge mclk);
    check(op, 1'b1);
    check({path_en, ld_start}, 2'h0);
    check(led_strap, 3'h0);
  endtask
  task automatic t_write_read();
    int w;
    int e;
    w = writes;
    e = errors;
    host.blk_wr(ADDR, 8'h10, 8'h03, 8'ha0);
    check(host.acks, 6);
    repeat (4) @(posedge mclk);
    check(writes - w, 1);
    host.blk_rd(ADDR, 8'h10, 3);
    check({host.acks[7:0], host.rcnt}, 16'h0320);
    for (int i = 0; i < 3; i++) begin
      check(host.rbuf[i], 8'ha0 + i);
    end
    check(errors - e, 0);
  endtask
  // Wrong address, general call, zero and oversize counts, then a bare start-stop.
  task automatic t_refuse();
    int w;
    int e;
    w = writes;
    e = errors;
    host.blk_wr(ADDR ^ 7'h01, 8'h10, 8'h01, 8'h11);
    check(host.acks, 0);
    host.blk_wr(7'h00, 8'h10, 8'h01, 8'h11);
    check(host.acks, 0);
    host.blk_wr(ADDR, 8'h10, 8'h00, 8'h11);
    check(host.acks, 2);
    host.blk_wr(ADDR, 8'h10, 8'h21, 8'h11);
    check(host.acks, 2);
    check(writes - w, 0);
    check(errors - e, 2);
    host.cond(1'b0);
    host.cond(1'b1);
    host.blk_wr(ADDR, 8'h11, 8'h01, 8'h55);
    check(host.acks, 4);
    host.blk_rd(ADDR, 8'h10, 2);
    check({host.rbuf[0], host.rbuf[1]}, 16'ha055);
  endtask
  // The clock is held low while the slave drives the first count bit.
  task automatic t_timeout();
    logic [7:0] junk;
    host.cond(1'b0);
    host.xfer({ADDR, 1'b0}, 1'b0, junk);
    host.xfer(8'h10, 1'b0, junk);
    host.cond(1'b0);
    host.xfer({ADDR, 1'b1}, 1'b0, junk);
    check({dut_oe, sdo}, 2'h2);
    repeat (TO + 40) @(posedge mclk);
    check(dut_oe, 1'b0);
    host.cond(1'b1);
    host.blk_rd(ADDR, 8'h10, 1);
    check(host.acks, 3);
  endtask
  task automatic t_attach();
    check(attach, 1'b0);
    host.blk_wr(ADDR, 8'hff, 8'h01, 8'h01);
    repeat (4) @(posedge mclk);
    check({attach, locked, ppc}, 5'h1f);
    host.blk_wr(ADDR, 8'h10, 8'h01, 8'h77);
    host.blk_rd(ADDR, 8'h10, 1);
    check(host.rbuf[0], 8'ha0);
    host.blk_wr(ADDR, 8'hff, 8'h01, 8'h02);
    repeat (OPC + 8) @(posedge mclk);
    check({attach, locked}, 2'h0);
    host.blk_rd(ADDR, 8'h10, 1);
    check(host.rbuf[0], 8'h00);
  endtask
  // Strap capture in default mode, then the stored-configuration load.
  task automatic t_modes();
    strap <= 3'h6;
    do_reset(1'b0, 1'b0);
    repeat (4) @(posedge mclk);
    check(led_strap, 3'h6);
    check(led_drive, 3'h6);
    led_on <= 1'b1;
    repeat (3) @(posedge mclk);
    check(led_drive, 3'h1);
    led_on <= 1'b0;
    do_reset(1'b1, 1'b0);
    repeat (OPC + 6) @(posedge mclk);
    check({path_en, ld_start}, 2'h3);
    load_done <= 1'b1;
    repeat (4) @(posedge mclk);
    check(ld_start, 1'b0);
  endtask
  // Main sequence.
  initial begin
    t_power_up();
    t_write_read();
    t_refuse();
    t_timeout();
    t_attach();
    t_modes();
    report_and_stop();
  end
endmodule
`default_nettype wire
